/* File: flash_bus_pkg.sv */
// Shared constants, operations and pin bundles for the flash bus controller.
package flash_bus_pkg;

   localparam int CLK_PERIOD_PS   = 8000;
   localparam int ADDR_W          = 18;
   localparam int DATA_W          = 16;
   localparam int BYTE_W          = 8;
   localparam int TOP_DQ_BIT      = 15;
   localparam int SYNC_LATENCY    = 3;
   localparam int CNT_W           = 8;

   // Bus cycle times in ns; plain defaults to be tuned for the fitted part.
   localparam int READ_WAIT_NS     = 100;
   localparam int WR_SETUP_NS      = 20;
   localparam int WR_PULSE_NS      = 50;
   localparam int WR_HOLD_NS       = 20;
   localparam int RESET_PULSE_NS   = 500;
   localparam int RESET_RECOVER_NS = 100;

   // Least times round up to whole cycles and never fall below one.
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cycles

   localparam int READ_WAIT_CYC  = ns_to_cycles(READ_WAIT_NS) + SYNC_LATENCY;
   localparam int WR_SETUP_CYC   = ns_to_cycles(WR_SETUP_NS);
   localparam int WR_PULSE_CYC   = ns_to_cycles(WR_PULSE_NS);
   localparam int WR_HOLD_CYC    = ns_to_cycles(WR_HOLD_NS);
   localparam int RST_PULSE_CYC  = ns_to_cycles(RESET_PULSE_NS);
   localparam int RST_RECOV_CYC  = ns_to_cycles(RESET_RECOVER_NS);

   // Address bits that select the protect or unprotect function.
   localparam int PROT_SEL_BIT    = 6;
   localparam int PROT_A1_BIT     = 1;
   localparam int PROT_A0_BIT     = 0;

   typedef enum logic [2:0] {
      OP_READ,
      OP_WRITE,
      OP_RESET,
      OP_PROTECT,
      OP_UNPROTECT
   } op_t;

   typedef struct packed {
      op_t                op;
      logic               byte_mode;
      logic [ADDR_W-1:0]  addr;
      logic               byte_lsb;
      logic [DATA_W-1:0]  data;
   } req_t;

   typedef struct packed {
      logic               chip_select_n;
      logic               output_enable_n;
      logic               write_strobe_n;
      logic               hw_reset_n;
      logic               width_select_n;
      logic               high_voltage_level;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  dq_out;
      logic [DATA_W-1:0]  dq_oe;
   } pins_t;

   localparam pins_t PINS_RESET = '{
      chip_select_n:      1'b1,
      output_enable_n:    1'b1,
      write_strobe_n:     1'b1,
      hw_reset_n:         1'b0,
      width_select_n:     1'b1,
      high_voltage_level: 1'b0,
      addr:               18'h00000,
      dq_out:             16'h0000,
      dq_oe:              16'h0000
   };

endpackage : flash_bus_pkg

/* File: pin_sync.sv */
// Three-stage input synchroniser that updates once the last two stages agree.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 17
) (
   // Clock and reset.
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // Pins in, filtered level out.
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   logic [W-1:0] next_level;

   // A bit still in motion keeps its old value; only agreeing bits pass.
   always_comb begin
      next_level = (~(ff2 ^ ff3) & ff2) | ((ff2 ^ ff3) & o_level);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1     <= '0;
         ff2     <= '0;
         ff3     <= '0;
         o_level <= '0;
      end else begin
         ff1     <= i_pin;
         ff2     <= ff1;
         ff3     <= ff2;
         o_level <= next_level;
      end
   end

endmodule : pin_sync

/* File: flash_bus_host.sv */
// Host-side bus cycle controller for a dual-bank parallel flash.
`timescale 1ns/1ps
module flash_bus_host
   import flash_bus_pkg::*;
(
   // Clock and reset.
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // User request port.
   input  wire logic              i_valid,
   input  req_t                   i_req,
   input  wire logic              i_temp_unprotect,
   output logic                   o_ready,
   output logic                   o_done,
   output logic [DATA_W-1:0]      o_rdata,
   // Flash pins.
   input  wire logic [DATA_W-1:0] i_dq,
   input  wire logic              i_ready_busy,
   output pins_t                  o_pins,
   output logic                   o_flash_ready
);

   typedef enum {
      ST_IDLE,
      ST_READ,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_HOLD,
      ST_RST_PULSE,
      ST_RST_RECOVER
   } state_t;

   state_t                state;
   state_t                next_state;
   logic [CNT_W-1:0]      cnt;
   logic [CNT_W-1:0]      next_cnt;
   req_t                  req;
   req_t                  next_req;
   pins_t                 next_pins;
   logic                  next_ready;
   logic                  next_done;
   logic [DATA_W-1:0]     next_rdata;
   logic [DATA_W:0]       synced;

   pin_sync #(
      .W       (DATA_W + 1)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   ({i_ready_busy, i_dq}),
      .o_level (synced)
   );

   function automatic logic is_last(input logic [CNT_W-1:0] c,
                                    input int cycles);
      return c == CNT_W'(cycles - 1);
   endfunction : is_last

   // Idle bus: deselected, strobes high, data released.
   function automatic pins_t idle_pins(input pins_t p, input logic hv);
      pins_t q;
      q                    = p;
      q.chip_select_n      = 1'b1;
      q.output_enable_n    = 1'b1;
      q.write_strobe_n     = 1'b1;
      q.hw_reset_n         = 1'b1;
      q.high_voltage_level = hv;
      q.dq_oe              = '0;
      return q;
   endfunction : idle_pins

   // Address, width and data drive for one request.
   function automatic pins_t cycle_pins(input pins_t p, input req_t r,
                                        input logic wr);
      pins_t q;
      q                = p;
      q.addr           = r.addr;
      q.width_select_n = ~r.byte_mode;
      q.dq_out         = r.data;
      q.dq_oe          = wr ? '1 : '0;
      if (r.byte_mode) begin
         // The top pin is an address input in byte mode, so it is driven
         // even on reads; bits 8 to 14 stay released.
         q.dq_out[TOP_DQ_BIT] = r.byte_lsb;
         q.dq_oe              = '0;
         q.dq_oe[TOP_DQ_BIT]  = 1'b1;
         if (wr) begin
            q.dq_oe[BYTE_W-1:0] = '1;
         end
      end
      if (r.op == OP_PROTECT || r.op == OP_UNPROTECT) begin
         q.addr[PROT_SEL_BIT] = (r.op == OP_UNPROTECT);
         q.addr[PROT_A1_BIT]  = 1'b1;
         q.addr[PROT_A0_BIT]  = 1'b0;
         q.high_voltage_level = 1'b1;
      end
      return q;
   endfunction : cycle_pins

   always_comb begin
      next_state = state;
      next_cnt   = cnt + CNT_W'(1);
      next_req   = req;
      next_pins  = o_pins;
      next_done  = 1'b0;
      next_rdata = o_rdata;
      case (state)
         ST_IDLE: begin
            next_cnt  = '0;
            next_pins = idle_pins(o_pins, i_temp_unprotect);
            if (i_valid && o_ready) begin
               next_req = i_req;
               case (i_req.op)
                  OP_RESET: begin
                     next_pins.hw_reset_n         = 1'b0;
                     next_pins.high_voltage_level = 1'b0;
                     next_state = ST_RST_PULSE;
                  end
                  OP_READ: begin
                     next_pins = cycle_pins(next_pins, i_req, 1'b0);
                     next_pins.chip_select_n   = 1'b0;
                     next_pins.output_enable_n = 1'b0;
                     next_state = ST_READ;
                  end
                  default: begin
                     // Each command write, bypass program included, is one
                     // bus cycle; the user chains two or four of them.
                     next_pins = cycle_pins(next_pins, i_req, 1'b1);
                     next_pins.chip_select_n = 1'b0;
                     next_state = ST_WR_SETUP;
                  end
               endcase
            end
         end
         ST_READ: begin
            if (is_last(cnt, READ_WAIT_CYC)) begin
               // Byte reads and identification codes use the low lane.
               next_rdata = req.byte_mode ?
                            {{(DATA_W-BYTE_W){1'b0}}, synced[BYTE_W-1:0]} :
                            synced[DATA_W-1:0];
               next_pins  = idle_pins(o_pins, i_temp_unprotect);
               next_done  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_WR_SETUP: begin
            if (is_last(cnt, WR_SETUP_CYC)) begin
               // Output enable is already high here, so no contention.
               next_pins.write_strobe_n = 1'b0;
               next_cnt   = '0;
               next_state = ST_WR_PULSE;
            end
         end
         ST_WR_PULSE: begin
            if (is_last(cnt, WR_PULSE_CYC)) begin
               next_pins.write_strobe_n = 1'b1;
               next_cnt   = '0;
               next_state = ST_WR_HOLD;
            end
         end
         ST_WR_HOLD: begin
            if (is_last(cnt, WR_HOLD_CYC)) begin
               next_pins  = idle_pins(o_pins, i_temp_unprotect);
               next_done  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_RST_PULSE: begin
            if (is_last(cnt, RST_PULSE_CYC)) begin
               next_pins.hw_reset_n = 1'b1;
               next_cnt   = '0;
               next_state = ST_RST_RECOVER;
            end
         end
         ST_RST_RECOVER: begin
            if (is_last(cnt, RST_RECOV_CYC)) begin
               next_done  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_pins  = PINS_RESET;
            next_cnt   = '0;
            next_state = ST_RST_PULSE;
         end
      endcase
      next_ready = (next_state == ST_IDLE) && !(i_valid && o_ready);
   end

   // Power-up starts with a full reset pulse so the device is in read mode.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state         <= ST_RST_PULSE;
         cnt           <= '0;
         req           <= '0;
         o_pins        <= PINS_RESET;
         o_ready       <= 1'b0;
         o_done        <= 1'b0;
         o_rdata       <= '0;
         o_flash_ready <= 1'b0;
      end else begin
         state         <= next_state;
         cnt           <= next_cnt;
         req           <= next_req;
         o_pins        <= next_pins;
         o_ready       <= next_ready;
         o_done        <= next_done;
         o_rdata       <= next_rdata;
         o_flash_ready <= synced[DATA_W];
      end
   end

endmodule : flash_bus_host

/* File: flash_bus_checker.sv */
// Pin-level assertions for the flash bus controller.
`timescale 1ns/1ps
module flash_bus_checker
   import flash_bus_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_temp_unprotect,
   input pins_t     o_pins
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_no_oe_we: assert property (!(!o_pins.output_enable_n &&
      !o_pins.write_strobe_n)) else $error("oe and strobe both low");
   a_read_hold: assert property ($fell(o_pins.output_enable_n) |->
      (!o_pins.chip_select_n && o_pins.write_strobe_n)[*8])
      else $error("read cycle pins broken");
   a_write_pulse: assert property ($fell(o_pins.write_strobe_n) |->
      (!o_pins.chip_select_n && o_pins.output_enable_n)[*7]
      ##1 o_pins.write_strobe_n) else $error("write strobe width wrong");
   a_read_release: assert property (!o_pins.output_enable_n |->
      o_pins.dq_oe[14:0] == 15'h0000) else $error("host drives on read");
   a_byte_upper: assert property (!o_pins.width_select_n |->
      o_pins.dq_oe[14:8] == 7'h00) else $error("upper byte driven");
   a_byte_lsb: assert property (!o_pins.width_select_n &&
      !o_pins.chip_select_n |-> o_pins.dq_oe[15])
      else $error("address lsb not driven");
   a_prot_addr: assert property (o_pins.high_voltage_level &&
      !o_pins.write_strobe_n && !i_temp_unprotect |->
      o_pins.addr[1] && !o_pins.addr[0]) else $error("protect address bad");
   a_reset_quiet: assert property (!o_pins.hw_reset_n |->
      o_pins.chip_select_n && o_pins.dq_oe == 16'h0000)
      else $error("bus active in reset");
endmodule : flash_bus_checker

bind flash_bus_host flash_bus_checker chk (
   .i_clk           (i_clk),
   .i_rst_n         (i_rst_n),
   .i_temp_unprotect(i_temp_unprotect),
   .o_pins          (o_pins)
);

/* File: flash_model.sv */
// Small behavioural model of the dual-bank flash seen at its pins.
`timescale 1ns/1ps
module flash_model
   import flash_bus_pkg::*;
(
   input  wire logic        i_clk,
   input  pins_t            i_pins,
   output logic [15:0]      o_dq,
   output logic [15:0]      o_dq_en,
   output logic             o_ready_busy
);
   // Only sixteen words are kept; the low address bits pick one.
   logic [15:0] mem [16];
   logic        sel;
   logic [3:0]  idx;
   assign sel = !i_pins.chip_select_n && i_pins.hw_reset_n;
   assign idx = i_pins.addr[3:0];
   assign o_ready_busy = 1'b1;
   // Reads need no command: the array is always readable.
   // Byte data and any code read sit on the low lane only.
   assign o_dq = (!i_pins.width_select_n) ?
      {8'h00, (i_pins.dq_out[15] ? mem[idx][15:8] : mem[idx][7:0])} :
      mem[idx];
   assign o_dq_en = (sel && !i_pins.output_enable_n) ?
      (i_pins.width_select_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
   // Writes land in a latch with no address of its own; here they
   // program directly, which is all the bench needs.
   // No sector is ever locked; writes are dropped only while the high-voltage level is high.
   always @(posedge i_clk) begin
      if (sel && !i_pins.write_strobe_n && !i_pins.high_voltage_level) begin
         if (i_pins.width_select_n) begin
            mem[idx] <= i_pins.dq_out;
         end else if (i_pins.dq_out[15]) begin
            mem[idx][15:8] <= i_pins.dq_out[7:0];
         end else begin
            mem[idx][7:0] <= i_pins.dq_out[7:0];
         end
      end
   end
endmodule : flash_model

/* File: tb.sv */
// Self-checking bench for the flash bus controller.
`timescale 1ns/1ps
module tb;
   import flash_bus_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_valid = 1'b0;
   req_t        i_req = '0;
   logic        i_temp_unprotect = 1'b0;
   logic        o_ready, o_done, o_flash_ready, rb, tog = 1'b0;
   logic [15:0] o_rdata, i_dq, dev_dq, dev_en;
   pins_t       o_pins;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc = 0;

   always #4 i_clk = ~i_clk;
   // Undriven lines toggle every cycle, so the synchroniser never passes them and keeps its old value.
   assign i_dq = (o_pins.dq_oe & o_pins.dq_out) | (dev_en & dev_dq) |
      (~(o_pins.dq_oe | dev_en) & {16{tog}});

   flash_bus_host dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
      .i_req(i_req), .i_temp_unprotect(i_temp_unprotect),
      .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .i_dq(i_dq),
      .i_ready_busy(rb), .o_pins(o_pins), .o_flash_ready(o_flash_ready));
   flash_model dev (.i_clk(i_clk), .i_pins(o_pins), .o_dq(dev_dq),
      .o_dq_en(dev_en), .o_ready_busy(rb));

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge i_clk) begin
      tog <= ~tog;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Issue one request, hold it until taken, then wait for completion.
   task automatic run_op(input op_t op, input logic bm,
      input logic [17:0] a, input logic lsb, input logic [15:0] d);
      i_req <= '{op: op, byte_mode: bm, addr: a, byte_lsb: lsb, data: d};
      i_valid <= 1'b1;
      do @(posedge i_clk); while (o_ready !== 1'b1);
      i_valid <= 1'b0;
      do @(posedge i_clk); while (o_done !== 1'b1);
   endtask : run_op

   task automatic t_word();
      run_op(OP_WRITE, 1'b0, 18'h00003, 1'b0, 16'hA5C3);
      run_op(OP_READ, 1'b0, 18'h00003, 1'b0, 16'h0000);
      chk(o_rdata, 16'hA5C3);
   endtask : t_word

   task automatic t_byte();
      run_op(OP_WRITE, 1'b1, 18'h00003, 1'b0, 16'h005A);
      run_op(OP_READ, 1'b1, 18'h00003, 1'b0, 16'h0000);
      chk(o_rdata, 16'h005A);
      run_op(OP_READ, 1'b1, 18'h00003, 1'b1, 16'h0000);
      chk(o_rdata, 16'h00A5);
   endtask : t_byte

   task automatic t_back_to_back();
      run_op(OP_WRITE, 1'b0, 18'h00005, 1'b0, 16'h1111);
      run_op(OP_WRITE, 1'b0, 18'h20006, 1'b0, 16'h2222);
      run_op(OP_READ, 1'b0, 18'h20006, 1'b0, 16'h0000);
      chk(o_rdata, 16'h2222);
      run_op(OP_READ, 1'b0, 18'h00005, 1'b0, 16'h0000);
      chk(o_rdata, 16'h1111);
   endtask : t_back_to_back

   task automatic t_protect();
      run_op(OP_PROTECT, 1'b0, 18'h30000, 1'b0, 16'h0000);
      run_op(OP_UNPROTECT, 1'b0, 18'h30000, 1'b0, 16'h0000);
      chk(o_pins.high_voltage_level, 1'b0);
      run_op(OP_READ, 1'b0, 18'h00003, 1'b0, 16'h0000);
      chk(o_rdata, 16'hA55A);
   endtask : t_protect

   // The high-voltage level follows the temporary unprotect input while
   // the bus idles or reads, and drops again once the input is cleared.
   task automatic t_temp_unprotect();
      i_temp_unprotect <= 1'b1;
      run_op(OP_READ, 1'b0, 18'h00005, 1'b0, 16'h0000);
      chk(o_pins.high_voltage_level, 1'b1);
      chk(o_rdata, 16'h1111);
      i_temp_unprotect <= 1'b0;
      run_op(OP_READ, 1'b0, 18'h00005, 1'b0, 16'h0000);
      chk(o_pins.high_voltage_level, 1'b0);
   endtask : t_temp_unprotect

   task automatic t_reset();
      run_op(OP_RESET, 1'b0, 18'h00000, 1'b0, 16'h0000);
      chk(o_pins.hw_reset_n, 1'b1);
      run_op(OP_READ, 1'b0, 18'h20006, 1'b0, 16'h0000);
      chk(o_rdata, 16'h2222);
   endtask : t_reset

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      do @(posedge i_clk); while (o_done !== 1'b1);
      chk(o_flash_ready, 1'b1);
      t_word();
      t_byte();
      t_back_to_back();
      t_protect();
      t_temp_unprotect();
      t_reset();
      tally_and_finish();
   end
endmodule : tb
